// *** gdsc_spi_slave.sv ***
// Purpose: Package of constants, and serial command slave for the gate driver start-up block
// Assumes: Serial pins arrive from another clock domain and are oversampled by clk (40 MHz)
// Notes: Frames are 16 bits, sampled on the rising serial clock edge, shifted on the falling one

`timescale 1ns/100ps
`default_nettype none

package gdsc_pkg;
  // ----------------------------------------------------------------
  // Frame format
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam logic [15:0] FRAME_CLEAR = 16'h3409; // Clear faults, set 5 V threshold
  localparam logic [15:0] FRAME_FAULT_REPORT_REG = 16'h8000; // Diagnostic read
  localparam logic [3:0] CFG_PREFIX = 4'h3; // Top nibble of a config write
  localparam int CFG_PREFIX_MSB = 15;
  localparam int CFG_PREFIX_LSB = 12;
  localparam int CFG_CLEAR_BIT = 3;
  localparam int CFG_THR_MSB = 1;
  localparam int CFG_THR_LSB = 0;
  // ----------------------------------------------------------------
  // Overvoltage threshold codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] THR_3V3 = 2'h2; // Power-up default
  localparam logic [1:0] THR_RESET = THR_3V3;
  localparam logic [1:0] FAULTS_RESET = 2'h0;
  localparam int FAULT_OV = 0; // Logic supply overvoltage
  localparam int FAULT_EXT = 1; // External fault event
  // ----------------------------------------------------------------
  // Synchronised input vector positions
  // ----------------------------------------------------------------
  localparam int IN_EN_A = 0;
  localparam int IN_EN_B = 1;
  localparam int IN_HIGH = 2; // Three bits, phases one to three
  localparam int IN_LOW = 5; // Three bits, phases one to three
  localparam int IN_TEST = 8;
  localparam int IN_SUP5 = 9;
  localparam int IN_FEVT = 10;
  localparam int IN_WIDTH = 11;
endpackage : gdsc_pkg

module gdsc_spi_slave (
  input wire logic clk,
  input wire logic reset,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_si,
  input wire logic [15:0] tx_word,
  output logic spi_so,
  output logic spi_so_oe,
  output logic frame_valid,
  output logic [15:0] frame_data
);
  import gdsc_pkg::*;

  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [2:0] last_reg;
  logic [15:0] rx_reg;
  logic [15:0] tx_reg;
  logic [4:0] cnt_reg;
  logic cs_fall, cs_rise, sck_rise, sck_fall, sel;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  // Two stages, then a history stage for edges; reset to idle pin levels
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= 3'h4;
      sync_reg <= 3'h4;
      last_reg <= 3'h4;
    end else begin
      meta_reg <= {spi_cs_n, spi_sck, spi_si};
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // Edges seen only on synchronised levels
  assign sel = ~sync_reg[2];
  assign cs_fall = ~sync_reg[2] & last_reg[2];
  assign cs_rise = sync_reg[2] & ~last_reg[2];
  assign sck_rise = sel & sync_reg[1] & ~last_reg[1];
  assign sck_fall = sel & ~sync_reg[1] & last_reg[1];

  // ----------------------------------------------------------------
  // Receive shifter, most significant bit first
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_reg <= 16'h0000;
      cnt_reg <= 5'h00;
    end else if (cs_fall) begin
      cnt_reg <= 5'h00;
    end else if (sck_rise) begin
      rx_reg <= {rx_reg[14:0], sync_reg[0]};
      if (cnt_reg != 5'h1f)
        cnt_reg <= cnt_reg + 5'h01;
    end
  end

  // Frame accepted only with exactly sixteen clocks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame_valid <= 1'b0;
      frame_data <= 16'h0000;
    end else begin
      frame_valid <= cs_rise && (cnt_reg == 5'(FRAME_BITS));
      if (cs_rise)
        frame_data <= rx_reg;
    end
  end

  // ----------------------------------------------------------------
  // Transmit shifter, status word out
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_reg <= 16'h0000;
    end else if (cs_fall) begin
      tx_reg <= tx_word;
    end else if (sck_fall) begin
      tx_reg <= {tx_reg[14:0], 1'b0};
    end
  end

  assign spi_so = tx_reg[15];
  assign spi_so_oe = sel; // Driven only while selected

  property p_frame_len;
    @(posedge clk) disable iff (reset)
    frame_valid |-> $past(cnt_reg, 1) == 5'h10;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("bad frame length");

  property p_so_load;
    @(posedge clk) disable iff (reset)
    cs_fall |=> spi_so == $past(tx_word[15]) && spi_so_oe;
  endproperty
  a_so_load: assert property (p_so_load) else $error("serial output not loaded");

endmodule : gdsc_spi_slave

`default_nettype wire

// *** gdsc_top.sv ***
// Purpose: Gate driver start-up, enable gating and fault latching
// Assumes: All pins are asynchronous to clk (40 MHz) and pass two flip-flops
// Notes: Analog paths are not modelled; sense outputs carry test data only

`timescale 1ns/100ps
`default_nettype none

module gdsc_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic gate_enable_a,
  input wire logic gate_enable_b,
  input wire logic high_cmd_phase_one,
  input wire logic high_cmd_phase_two,
  input wire logic high_cmd_phase_three,
  input wire logic low_cmd_phase_one,
  input wire logic low_cmd_phase_two,
  input wire logic low_cmd_phase_three,
  input wire logic test_mode_enable,
  input wire logic supply_is_5v,
  input wire logic fault_event,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  output logic gate_high_one,
  output logic gate_high_two,
  output logic gate_high_three,
  output logic gate_low_one,
  output logic gate_low_two,
  output logic gate_low_three,
  output logic fault_flag_n,
  output logic sense_out_one,
  output logic sense_out_two,
  output logic [1:0] ov_threshold,
  output logic fault_report_reg_read_done
);
  import gdsc_pkg::*;

  logic [IN_WIDTH-1:0] in_meta_reg;
  logic [IN_WIDTH-1:0] in_sync_reg;
  logic [2:0] high_reg;
  logic [2:0] low_reg;
  logic [1:0] thr_reg;
  logic [1:0] fault_reg;
  logic [1:0] fault_next;
  logic fault_flag_n_reg;
  logic sense_one_reg;
  logic sense_two_reg;
  logic fault_report_reg_reg;
  logic frame_valid;
  logic [15:0] frame_data;
  logic [15:0] status_word;
  logic enabled, any_fault, cfg_write, clear_cmd;
  logic [2:0] high_s, low_s;
  logic [1:0] thr_eff;

  // Overvoltage when the 3.3 V threshold meets a 5 V supply
  function automatic logic ov_trip(input logic [1:0] thr, input logic sup5);
    ov_trip = sup5 && (thr == THR_3V3);
  endfunction : ov_trip

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Two flip-flops on every pin
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      in_meta_reg <= '0;
      in_sync_reg <= '0;
    end else begin
      in_meta_reg <= {fault_event, supply_is_5v, test_mode_enable,
                      low_cmd_phase_three, low_cmd_phase_two, low_cmd_phase_one,
                      high_cmd_phase_three, high_cmd_phase_two, high_cmd_phase_one,
                      gate_enable_b, gate_enable_a};
      in_sync_reg <= in_meta_reg;
    end
  end

  assign enabled = in_sync_reg[IN_EN_A] & in_sync_reg[IN_EN_B];
  assign high_s = in_sync_reg[IN_HIGH +: 3];
  assign low_s = in_sync_reg[IN_LOW +: 3];

  // ----------------------------------------------------------------
  // Gate drive outputs
  // ----------------------------------------------------------------
  // Enables ANDed; both sides of a phase on is refused as shoot-through
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      high_reg <= 3'h0;
      low_reg <= 3'h0;
    end else if (!enabled) begin
      high_reg <= 3'h0;
      low_reg <= 3'h0;
    end else begin
      high_reg <= high_s & ~low_s;
      low_reg <= low_s & ~high_s;
    end
  end

  assign gate_high_one = high_reg[0];
  assign gate_high_two = high_reg[1];
  assign gate_high_three = high_reg[2];
  assign gate_low_one = low_reg[0];
  assign gate_low_two = low_reg[1];
  assign gate_low_three = low_reg[2];

  // ----------------------------------------------------------------
  // Serial command port
  // ----------------------------------------------------------------
  assign status_word = {fault_report_reg_reg, 11'h000, thr_reg, fault_reg};

  gdsc_spi_slave u_spi (
    .clk(clk),
    .reset(reset),
    .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck),
    .spi_si(spi_si),
    .tx_word(status_word),
    .spi_so(spi_so),
    .spi_so_oe(spi_so_oe),
    .frame_valid(frame_valid),
    .frame_data(frame_data)
  );

  assign cfg_write = frame_valid && (frame_data[CFG_PREFIX_MSB:CFG_PREFIX_LSB] == CFG_PREFIX);
  assign clear_cmd = cfg_write && frame_data[CFG_CLEAR_BIT];

  // Threshold field, written by a config frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      thr_reg <= THR_RESET;
    else if (cfg_write)
      thr_reg <= frame_data[CFG_THR_MSB:CFG_THR_LSB];
  end

  // Diagnostic frame marks the report as read
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      fault_report_reg_reg <= 1'b0;
    else if (frame_valid && frame_data == FRAME_FAULT_REPORT_REG)
      fault_report_reg_reg <= 1'b1;
  end

  assign ov_threshold = thr_reg;
  assign fault_report_reg_read_done = fault_report_reg_reg;

  // ----------------------------------------------------------------
  // Fault latch and flag
  // ----------------------------------------------------------------
  // Trip judged on the threshold being written, so a clear that also
  // lifts the threshold is not undone by the old code
  assign thr_eff = cfg_write ? frame_data[CFG_THR_MSB:CFG_THR_LSB] : thr_reg;

  // New events win over a clear in the same cycle
  always_comb begin
    fault_next = clear_cmd ? 2'h0 : fault_reg;
    if (ov_trip(thr_eff, in_sync_reg[IN_SUP5]))
      fault_next[FAULT_OV] = 1'b1;
    if (in_sync_reg[IN_FEVT])
      fault_next[FAULT_EXT] = 1'b1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      fault_reg <= FAULTS_RESET;
    else
      fault_reg <= fault_next;
  end

  assign any_fault = |fault_reg;

  // Active-low flag
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      fault_flag_n_reg <= 1'b1;
    else
      fault_flag_n_reg <= ~any_fault;
  end

  assign fault_flag_n = fault_flag_n_reg;

  // ----------------------------------------------------------------
  // Test mode digital outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sense_one_reg <= 1'b0;
      sense_two_reg <= 1'b0;
    end else begin
      sense_one_reg <= in_sync_reg[IN_TEST] & fault_reg[FAULT_OV];
      sense_two_reg <= in_sync_reg[IN_TEST] & fault_reg[FAULT_EXT];
    end
  end

  assign sense_out_one = sense_one_reg;
  assign sense_out_two = sense_two_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_gate_off;
    @(posedge clk) disable iff (reset)
    !(in_sync_reg[IN_EN_A] && in_sync_reg[IN_EN_B]) |=> (high_reg == 3'h0) && (low_reg == 3'h0);
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gate on while disabled");

  property p_high_cmd;
    @(posedge clk) disable iff (reset)
    enabled && high_s[0] && !low_s[0] |=> gate_high_one && !gate_low_one;
  endproperty
  a_high_cmd: assert property (p_high_cmd) else $error("high command not followed");

  property p_low_cmd;
    @(posedge clk) disable iff (reset)
    enabled && low_s[2] && !high_s[2] |=> gate_low_three && !gate_high_three;
  endproperty
  a_low_cmd: assert property (p_low_cmd) else $error("low command not followed");

  property p_thr_default;
    @(posedge clk) disable iff (reset)
    $past(reset) |-> thr_reg == 2'h2;
  endproperty
  a_thr_default: assert property (p_thr_default) else $error("threshold reset wrong");

  property p_ov_latch;
    @(posedge clk) disable iff (reset)
    in_sync_reg[IN_SUP5] && thr_reg == 2'h2 && !cfg_write
      |=> fault_reg[FAULT_OV] ##1 !fault_flag_n;
  endproperty
  a_ov_latch: assert property (p_ov_latch) else $error("5 V supply fault not latched");

  property p_flag;
    @(posedge clk) disable iff (reset)
    ##1 fault_flag_n == !$past(any_fault);
  endproperty
  a_flag: assert property (p_flag) else $error("fault flag wrong");

  property p_test_out;
    @(posedge clk) disable iff (reset)
    in_sync_reg[IN_TEST] |=> sense_out_one == $past(fault_reg[FAULT_OV]);
  endproperty
  a_test_out: assert property (p_test_out) else $error("test output one wrong");

  property p_clear_frame;
    @(posedge clk) disable iff (reset)
    frame_valid && frame_data == 16'h3409 |=> thr_reg == 2'h1 && !fault_reg[FAULT_OV];
  endproperty
  a_clear_frame: assert property (p_clear_frame) else $error("clear frame ignored");

  property p_fault_report_reg_frame;
    @(posedge clk) disable iff (reset)
    frame_valid && frame_data == 16'h8000 |=> fault_report_reg_read_done [*3];
  endproperty
  a_fault_report_reg_frame: assert property (p_fault_report_reg_frame) else $error("fault_report_reg frame ignored");

endmodule : gdsc_top

`default_nettype wire

// *** gdsc_host_model.sv ***
// Purpose: Host model that sends serial command frames to the gate driver block
// Assumes: Mode 0, serial clock period 200 ns (8 clk), idle low outside frames
// Notes: Data in shows the inverse of the last bit once the frame is over

`timescale 1ns/100ps
`default_nettype none

module gdsc_host_model (
  input wire logic clk,
  input wire logic spi_so,
  output logic spi_cs_n,
  output logic spi_sck,
  output logic spi_si
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_si = 1'b0;
  end

  // ----------------------------------------------------------------
  // One frame: the first n bits of the word, msb first, in one select window
  // ----------------------------------------------------------------
  task automatic send_bits(input logic [15:0] word, input int n, output logic [15:0] rx);
    @(posedge clk);
    #1 spi_cs_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      spi_si = word[i];
      repeat (4) @(posedge clk);
      #1 spi_sck = 1'b1;
      rx[i] = spi_so; // Reply bit taken on the rising edge
      repeat (4) @(posedge clk);
      #1 spi_sck = 1'b0;
    end
    repeat (4) @(posedge clk);
    #1 spi_cs_n = 1'b1;
    spi_si = ~spi_si; // Released line no longer shows the last bit
    repeat (8) @(posedge clk); // Gap between frames
    #1;
  endtask : send_bits

  // Full-length frame
  task automatic send(input logic [15:0] word, output logic [15:0] rx);
    send_bits(word, 16, rx);
  endtask : send
endmodule : gdsc_host_model

`default_nettype wire

// *** gdsc_top_tb.sv ***
// Purpose: Self-checking bench for the gate driver start-up block
// Assumes: Pin to gate latency of 3 clk, frame effects within 8 clk of select release
// Notes: Table of enable and command cases, then a 5 V start-up after a second reset

`timescale 1ns/100ps
`default_nettype none

module gdsc_top_tb;
  import gdsc_pkg::*;
  logic clk, reset, en_a, en_b, test_mode, sup5, fevt, cs_n, sck, si, so, so_oe;
  logic [2:0] hi, lo, g_hi, g_lo;
  logic flag_n, s1, s2, fault_report_reg;
  logic [1:0] thr;
  logic [15:0] rx;
  int n_mismatch = 0;
  int tests_run = 0;
  // Rows: {en_b, en_a, high[2:0], low[2:0], gate high[2:0], gate low[2:0]}
  logic [13:0] rows [7] = '{14'h3208, 14'h1e00, 14'h21c0, 14'h3555, 14'h3900,
    14'h0700, 14'h371c};

  gdsc_top dut_u (.clk(clk), .reset(reset), .gate_enable_a(en_a), .gate_enable_b(en_b),
    .high_cmd_phase_one(hi[0]), .high_cmd_phase_two(hi[1]), .high_cmd_phase_three(hi[2]),
    .low_cmd_phase_one(lo[0]), .low_cmd_phase_two(lo[1]), .low_cmd_phase_three(lo[2]),
    .test_mode_enable(test_mode), .supply_is_5v(sup5), .fault_event(fevt),
    .spi_cs_n(cs_n), .spi_sck(sck), .spi_si(si), .spi_so(so), .spi_so_oe(so_oe),
    .gate_high_one(g_hi[0]), .gate_high_two(g_hi[1]), .gate_high_three(g_hi[2]),
    .gate_low_one(g_lo[0]), .gate_low_two(g_lo[1]), .gate_low_three(g_lo[2]),
    .fault_flag_n(flag_n), .sense_out_one(s1), .sense_out_two(s2),
    .ov_threshold(thr), .fault_report_reg_read_done(fault_report_reg));

  gdsc_host_model host_u (.clk(clk), .spi_so(so), .spi_cs_n(cs_n), .spi_sck(sck),
    .spi_si(si));

  // ----------------------------------------------------------------
  // Clock and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {en_a, en_b, test_mode, sup5, fevt} = 5'h0;
    hi = 3'h0;
    lo = 3'h0;
    settle(3);
    reset = 1'b0;
    settle(2);
    // Enable and command table at 3.3 V, no faults
    foreach (rows[r]) begin
      {en_b, en_a, hi, lo} = rows[r][13:6];
      settle(4);
      chk({10'h0, g_hi, g_lo}, {10'h0, rows[r][5:0]}, "gate outputs");
    end
    // Second reset at 5 V with both enables held low
    {en_a, en_b, hi, lo} = 8'h0;
    sup5 = 1'b1;
    test_mode = 1'b1;
    reset = 1'b1;
    settle(3);
    chk({14'h0, thr}, {14'h0, THR_3V3}, "threshold in reset");
    chk({10'h0, flag_n, so_oe, fault_report_reg, s1, s2, g_hi[0]}, 16'h0020, "reset outputs");
    reset = 1'b0;
    settle(6);
    chk({15'h0, flag_n}, 16'h0000, "overvoltage fault at 5 V");
    chk({14'h0, s1, s2}, 16'h0002, "test outputs with fault");
    host_u.send(FRAME_CLEAR, rx);
    chk(rx, 16'h0009, "status word before clear");
    chk({13'h0, thr, flag_n}, 16'h0003, "threshold and flag after clear");
    chk({14'h0, s1, s2}, 16'h0000, "test outputs cleared");
    host_u.send(16'h5a5a, rx);
    chk({14'h0, thr}, 16'h0001, "unknown frame ignored");
    host_u.send(FRAME_FAULT_REPORT_REG, rx);
    chk(rx, 16'h0004, "status word before diagnostic");
    for (int k = 0; k < 20 && fault_report_reg !== 1'b1; k++) begin
      settle(1);
    end
    chk({15'h0, fault_report_reg}, 16'h0001, "diagnostic read flag");
    // Enable after the diagnostic, then commands
    {en_a, en_b} = 2'h3;
    settle(1);
    hi = 3'h1;
    settle(4);
    chk({13'h0, g_hi}, 16'h0001, "gate after start-up");
    // External fault held through a clear frame
    fevt = 1'b1;
    settle(6);
    chk({14'h0, flag_n, s2}, 16'h0001, "external fault latched");
    test_mode = 1'b0;
    settle(4);
    chk({14'h0, s1, s2}, 16'h0000, "test outputs outside test mode");
    host_u.send(FRAME_CLEAR, rx);
    chk(rx, 16'h8006, "status word with event");
    chk({15'h0, flag_n}, 16'h0000, "set wins over clear");
    fevt = 1'b0;
    settle(4);
    host_u.send_bits(FRAME_CLEAR, 15, rx);
    chk({15'h0, flag_n}, 16'h0000, "short frame refused");
    host_u.send(FRAME_CLEAR, rx);
    chk({15'h0, flag_n}, 16'h0001, "flag released");
    end_of_test();
  end

  // Overall limit on the run
  initial begin
    #2000000;
    n_mismatch++;
    $display("ERROR at %0t: run limit reached", $time);
    end_of_test();
  end
endmodule : gdsc_top_tb

`default_nettype wire
